//--- hdl/rmc_pkg.sv
// Shared constants and types for the receiver control register slice
package rmc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_OFFSET      = 8'h00;
	localparam logic [7:0] MISC_OFFSET      = 8'h06;
	localparam logic [7:0] TEST_BASE_OFFSET = 8'h07;
	localparam int         TEST_REG_COUNT   = 9;

	// ----------------------------------------------------------------
	// Register layouts and reset values
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] unused;
		logic       test_mode;
		logic       band_inhibit;
		logic       powerdown_request;
	} rmc_mode_t;

	typedef struct packed {
		logic       synth_test_bit;
		logic       reserved;
		logic       logic_out_topology;
		logic       logic_out_level;
		logic [1:0] postmix_gain_sel;
		logic       aux_filter_off;
		logic       channel_filter_off;
	} rmc_misc_t;

	localparam logic [7:0] MODE_RESET      = 8'h00;
	localparam logic [7:0] MISC_RESET      = 8'h00;
	localparam logic [7:0] TEST_RESET      = 8'h00;
	localparam logic [7:0] MODE_WRITE_MASK = 8'h07;
	localparam logic [7:0] MISC_WRITE_MASK = 8'hbf;

	// ----------------------------------------------------------------
	// Post-mixer amplifier gain in dB per code
	// ----------------------------------------------------------------
	localparam logic [4:0] GAIN_CODE0_DB = 5'h0d;
	localparam logic [4:0] GAIN_CODE1_DB = 5'h0b;
	localparam logic [4:0] GAIN_CODE2_DB = 5'h0f;
	localparam logic [4:0] GAIN_CODE3_DB = 5'h0d;

	// ----------------------------------------------------------------
	// Bus addressing; base value is arbitrary
	// ----------------------------------------------------------------
	localparam logic [4:0] BUS_ADDR_BASE = 5'h18;

	// ----------------------------------------------------------------
	// Power modes and block enables
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PM_DEEP_SLEEP,
		PM_NORMAL,
		PM_LOW_POWER,
		PM_POWER_DOWN
	} rmc_power_mode_t;

	typedef struct packed {
		logic ref_osc_en;
		logic clk_out_buf_en;
		logic vco_regulator_en;
		logic rx_chain_en;
		logic bb_agc_en;
		logic channel_filter_en;
		logic aux_filter_en;
	} rmc_block_en_t;

endpackage

//--- hdl/rmc_ctrl.sv
// Receiver control register slice: two-wire slave, registers, power mode decode
// Summary of operation
// R01: Misc register bits 5-0 and 7 read/write; bit 6 reads zero, ignores writes.
// R02: Host keeps the synthesiser test bit at zero for normal operation.
// R03: Topology bit one gives open-drain pull-down pad, zero gives push-pull.
// R04: Logic output pad is driven to the level bit's value.
// R05: Gain code 00/01/10/11 selects 13/11/15/13 dB post-mixer gain.
// R06: Aux filter off bit one disables the complementary lowpass stage.
// R07: Channel filter off bit one disables both channel filter sections.
// R08: Test and status registers read zero and ignore writes outside test mode.
// R09: Enable high: power down if requested, low power if channel filter off, else normal.
// R10: Enable pin low forces deep sleep regardless of register bits.
// R11: Deep sleep clears the power down request bit.
// R12: Host waits 20 ms after power down and 200 ms after deep sleep.
// R13: Power down keeps oscillator, clock buffer, VCO regulator and registers alive.
// R14: Power-on reset still acts in deep sleep; registers otherwise retained.
// R15: Deep sleep ignores reset pin and address select pins.
// R16: Baseband gain control is unaffected by filter disable bits.
// R17: Mode register bits 2-0 read/write; bits 7-3 read zero.
// R18: Power mode decode follows pin and registers continuously.
// R19: Control registers reset on power-on reset or reset pin outside deep sleep.
`timescale 1ns/100ps
`default_nettype none
module rmc_ctrl
(
	// Clock and power-on reset
	input  wire logic                    core_clk,
	input  wire logic                    arst_n,
	// Device pins
	input  wire logic                    enable_pin,
	input  wire logic                    rst_pin_n,
	input  wire logic                    addr_select_pin0,
	input  wire logic                    addr_select_pin1,
	// Two-wire bus
	input  wire logic                    scl_in,
	input  wire logic                    sda_in,
	output logic                         sda_out,
	output logic                         sda_oe,
	// Logic output pad
	output logic                         logic_output_pad_out,
	output logic                         logic_output_pad_oe,
	// Analog controls
	output logic [4:0]                   post_mixer_amp_gain_db,
	output rmc_pkg::rmc_block_en_t       block_en,
	output rmc_pkg::rmc_power_mode_t     power_mode
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic       scl_d_reg;
	logic       sda_d_reg;
	logic       sda_s1_reg;
	logic       sda_s;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_reg <= 5'h1f;
			sync2_reg <= 5'h1f;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			sync1_reg <= {enable_pin, rst_pin_n, addr_select_pin1, addr_select_pin0, scl_in};
			sync2_reg <= sync1_reg;
			scl_d_reg <= sync2_reg[0];
			sda_d_reg <= sda_s;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sda_s1_reg <= 1'b1;
			sda_s      <= 1'b1;
		end
		else
		begin
			sda_s1_reg <= sda_in;
			sda_s      <= sda_s1_reg;
		end
	end

	logic enable_s;
	logic rst_pin_s_n;
	logic scl_s;
	assign enable_s    = sync2_reg[4];
	assign rst_pin_s_n = sync2_reg[3];
	assign scl_s       = sync2_reg[0];

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise  = scl_s && !scl_d_reg;
	assign scl_fall  = !scl_s && scl_d_reg;
	assign bus_start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
	assign bus_stop  = scl_s && scl_d_reg && !sda_d_reg && sda_s;

	// ----------------------------------------------------------------
	// Deep sleep gating of pin functions
	// ----------------------------------------------------------------
	logic       deep_sleep;
	logic       soft_rst;
	logic [1:0] addr_pins_reg;
	assign deep_sleep = !enable_s;                                   // R10
	assign soft_rst   = !rst_pin_s_n && !deep_sleep;                 // R15 R19

	// Address pins only taken outside deep sleep
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			addr_pins_reg <= 2'h0;
		else if (!deep_sleep)                                        // R15
			addr_pins_reg <= sync2_reg[2:1];
	end

	// ----------------------------------------------------------------
	// Two-wire slave engine
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK} rmc_bus_st_t;
	rmc_bus_st_t bus_st_reg;
	logic [7:0]  shift_reg;
	logic [2:0]  bit_cnt_reg;
	logic        read_reg;
	logic        ptr_done_reg;
	logic        ack_read_reg;
	logic [7:0]  reg_ptr_reg;
	logic        byte_done_reg;
	logic        wr_pulse;
	logic [7:0]  wr_data;
	logic [7:0]  rd_data;
	logic [7:0]  rx_byte;
	assign rx_byte = {shift_reg[6:0], sda_s};
	assign wr_data = shift_reg;
	assign wr_pulse = (bus_st_reg == ST_RX) && scl_fall && byte_done_reg && ptr_done_reg;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bus_st_reg   <= ST_IDLE;
			shift_reg    <= 8'h00;
			bit_cnt_reg  <= 3'h0;
			read_reg     <= 1'b0;
			ptr_done_reg <= 1'b0;
			ack_read_reg <= 1'b0;
			reg_ptr_reg  <= 8'h00;
			byte_done_reg <= 1'b0;
			sda_oe       <= 1'b0;
		end
		else if (bus_stop || soft_rst)
		begin
			bus_st_reg <= ST_IDLE;
			sda_oe     <= 1'b0;
		end
		else if (bus_start)
		begin
			bus_st_reg   <= ST_ADDR;
			bit_cnt_reg  <= 3'h0;
			ptr_done_reg <= 1'b0;
			byte_done_reg <= 1'b0;
			sda_oe       <= 1'b0;
		end
		else
		begin
			unique case (bus_st_reg)
				ST_IDLE:
					sda_oe <= 1'b0;
				ST_ADDR, ST_RX:
				begin
					if (scl_rise)
					begin
						shift_reg     <= rx_byte;
						bit_cnt_reg   <= bit_cnt_reg + 3'h1;
						byte_done_reg <= bit_cnt_reg == 3'h7;
					end
					// A byte needs eight rising edges; the fall just after START is no byte end
					if (scl_fall && byte_done_reg)
					begin
						byte_done_reg <= 1'b0;
						if (bus_st_reg == ST_ADDR)
						begin
							if (shift_reg[7:1] == {rmc_pkg::BUS_ADDR_BASE, addr_pins_reg})
							begin
								read_reg   <= shift_reg[0];
								sda_oe     <= 1'b1;
								bus_st_reg <= ST_ACK;
							end
							else
								bus_st_reg <= ST_IDLE;
						end
						else
						begin
							if (!ptr_done_reg)
								reg_ptr_reg <= shift_reg;
							else
								reg_ptr_reg <= reg_ptr_reg + 8'h01;
							ptr_done_reg <= 1'b1;
							ack_read_reg <= 1'b0;
							sda_oe       <= 1'b1;
							bus_st_reg   <= ST_ACK;
						end
					end
				end
				ST_ACK:
					if (scl_fall)
					begin
						bit_cnt_reg <= 3'h0;
						if (read_reg)
						begin
							shift_reg  <= {rd_data[6:0], 1'b0};
							sda_oe     <= !rd_data[7];
							bus_st_reg <= ST_TX;
						end
						else
						begin
							sda_oe     <= 1'b0;
							bus_st_reg <= ST_RX;
						end
					end
				ST_TX:
					if (scl_fall)
					begin
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						if (bit_cnt_reg == 3'h7)
						begin
							sda_oe      <= 1'b0;
							reg_ptr_reg <= reg_ptr_reg + 8'h01;
							bus_st_reg  <= ST_MACK;
						end
						else
						begin
							sda_oe    <= !shift_reg[7];
							shift_reg <= {shift_reg[6:0], 1'b0};
						end
					end
				ST_MACK:
				begin
					if (scl_rise)
						ack_read_reg <= !sda_s;
					if (scl_fall)
					begin
						bit_cnt_reg <= 3'h0;
						if (ack_read_reg)
						begin
							shift_reg  <= {rd_data[6:0], 1'b0};
							sda_oe     <= !rd_data[7];
							bus_st_reg <= ST_TX;
						end
						else
							bus_st_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Open-drain bus: only ever pulls low
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	rmc_pkg::rmc_mode_t mode_reg;
	rmc_pkg::rmc_misc_t misc_control_reg;
	logic [7:0]         test_mem [rmc_pkg::TEST_REG_COUNT];
	logic [7:0]         test_idx;
	logic               test_hit;
	assign test_idx = reg_ptr_reg - rmc_pkg::TEST_BASE_OFFSET;
	assign test_hit = reg_ptr_reg >= rmc_pkg::TEST_BASE_OFFSET
		&& test_idx < 8'(rmc_pkg::TEST_REG_COUNT);

	// Pin-driven clear wins over a concurrent write of the request bit
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)                                                 // R14
			mode_reg <= rmc_pkg::MODE_RESET;
		else if (soft_rst)                                           // R19
			mode_reg <= rmc_pkg::MODE_RESET;
		else
		begin
			if (wr_pulse && reg_ptr_reg == rmc_pkg::MODE_OFFSET)
				mode_reg <= wr_data & rmc_pkg::MODE_WRITE_MASK;      // R17
			if (deep_sleep)
				mode_reg.powerdown_request <= 1'b0;                  // R11
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			misc_control_reg <= rmc_pkg::MISC_RESET;
		else if (soft_rst)                                           // R19
			misc_control_reg <= rmc_pkg::MISC_RESET;
		else if (wr_pulse && reg_ptr_reg == rmc_pkg::MISC_OFFSET)
			misc_control_reg <= wr_data & rmc_pkg::MISC_WRITE_MASK;  // R01
	end

	// Test storage keeps its contents but is only written and read while test mode is set
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < rmc_pkg::TEST_REG_COUNT; i++)
				test_mem[i] <= rmc_pkg::TEST_RESET;
		end
		else if (soft_rst)
		begin
			for (int i = 0; i < rmc_pkg::TEST_REG_COUNT; i++)
				test_mem[i] <= rmc_pkg::TEST_RESET;
		end
		else if (wr_pulse && test_hit && mode_reg.test_mode)        // R08
			test_mem[test_idx[3:0]] <= wr_data;
	end

	always_comb
	begin
		rd_data = 8'h00;
		if (reg_ptr_reg == rmc_pkg::MODE_OFFSET)
			rd_data = mode_reg;
		else if (reg_ptr_reg == rmc_pkg::MISC_OFFSET)
			rd_data = misc_control_reg;
		else if (test_hit && mode_reg.test_mode)                     // R08
			rd_data = test_mem[test_idx[3:0]];
	end

	// ----------------------------------------------------------------
	// Power mode decode and analog controls
	// ----------------------------------------------------------------
	rmc_pkg::rmc_power_mode_t mode_next;
	always_comb
	begin
		if (deep_sleep)                                              // R10
			mode_next = rmc_pkg::PM_DEEP_SLEEP;
		else if (mode_reg.powerdown_request)                         // R09
			mode_next = rmc_pkg::PM_POWER_DOWN;
		else if (misc_control_reg.channel_filter_off)
			mode_next = rmc_pkg::PM_LOW_POWER;
		else
			mode_next = rmc_pkg::PM_NORMAL;
	end

	logic rx_on;
	assign rx_on = mode_next == rmc_pkg::PM_NORMAL || mode_next == rmc_pkg::PM_LOW_POWER;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			power_mode <= rmc_pkg::PM_DEEP_SLEEP;
			block_en   <= '0;
		end
		else
		begin
			power_mode                 <= mode_next;                 // R18
			block_en.ref_osc_en        <= !deep_sleep;               // R13
			block_en.clk_out_buf_en    <= !deep_sleep;
			block_en.vco_regulator_en  <= !deep_sleep;
			block_en.rx_chain_en       <= rx_on;
			block_en.bb_agc_en         <= rx_on;                     // R16
			block_en.channel_filter_en <= rx_on && !misc_control_reg.channel_filter_off; // R07
			block_en.aux_filter_en     <= rx_on && !misc_control_reg.aux_filter_off;     // R06
		end
	end

	// Gain is a static setting so it stays valid across power modes
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			post_mixer_amp_gain_db <= rmc_pkg::GAIN_CODE0_DB;
		else
			unique case (misc_control_reg.postmix_gain_sel)          // R05
				2'h0: post_mixer_amp_gain_db <= rmc_pkg::GAIN_CODE0_DB;
				2'h1: post_mixer_amp_gain_db <= rmc_pkg::GAIN_CODE1_DB;
				2'h2: post_mixer_amp_gain_db <= rmc_pkg::GAIN_CODE2_DB;
				2'h3: post_mixer_amp_gain_db <= rmc_pkg::GAIN_CODE3_DB;
			endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			logic_output_pad_out <= 1'b0;
			logic_output_pad_oe  <= 1'b1;
		end
		else if (misc_control_reg.logic_out_topology)                // R03
		begin
			logic_output_pad_out <= 1'b0;
			logic_output_pad_oe  <= !misc_control_reg.logic_out_level; // R04
		end
		else
		begin
			logic_output_pad_out <= misc_control_reg.logic_out_level;  // R04
			logic_output_pad_oe  <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	misc_bit6_zero_a: assert property (misc_control_reg.reserved == 1'b0) // R01
		else $error("misc bit 6 not zero");
	mode_upper_zero_a: assert property (mode_reg.unused == 5'h00) // R17
		else $error("mode upper bits not zero");
	sleep_mode_a: assert property (!enable_s |=> power_mode == rmc_pkg::PM_DEEP_SLEEP) // R10
		else $error("deep sleep not entered");
	sleep_clears_pd_a: assert property (!enable_s |=> !mode_reg.powerdown_request) // R11
		else $error("power down request kept in deep sleep");
	pd_decode_a: assert property (enable_s && mode_reg.powerdown_request
		|=> power_mode == rmc_pkg::PM_POWER_DOWN && !block_en.rx_chain_en
		&& block_en.ref_osc_en && block_en.vco_regulator_en) // R09 R13
		else $error("power down decode wrong");
	low_power_a: assert property (enable_s && !mode_reg.powerdown_request
		&& misc_control_reg.channel_filter_off
		|=> power_mode == rmc_pkg::PM_LOW_POWER && !block_en.channel_filter_en) // R09 R07
		else $error("low power decode wrong");
	agc_kept_a: assert property (power_mode == rmc_pkg::PM_LOW_POWER |-> block_en.bb_agc_en) // R16
		else $error("agc lost in low power");
	test_read_zero_a: assert property (!mode_reg.test_mode && test_hit |-> rd_data == 8'h00) // R08
		else $error("test register visible");
	pad_open_drain_a: assert property ($rose(misc_control_reg.logic_out_topology)
		|=> !logic_output_pad_out && logic_output_pad_oe == !$past(misc_control_reg.logic_out_level)) // R03 R04
		else $error("open drain pad wrong");
	gain_code2_a: assert property (misc_control_reg.postmix_gain_sel == 2'h2
		|=> post_mixer_amp_gain_db == 5'h0f) // R05
		else $error("gain code 2 wrong");
	pin_reset_a: assert property (soft_rst |=> misc_control_reg == rmc_pkg::MISC_RESET) // R19
		else $error("reset pin ignored");
	sleep_no_reset_a: assert property (deep_sleep && !rst_pin_s_n && !wr_pulse
		|=> misc_control_reg == $past(misc_control_reg)) // R15
		else $error("reset pin acted in deep sleep");

	write_misc_c: cover property (wr_pulse && reg_ptr_reg == rmc_pkg::MISC_OFFSET);
	read_byte_c: cover property (bus_st_reg == ST_MACK && scl_fall && !ack_read_reg);
	pd_entry_c: cover property (power_mode == rmc_pkg::PM_POWER_DOWN ##1 !enable_s);
	test_write_c: cover property (wr_pulse && test_hit && mode_reg.test_mode);

endmodule
`default_nettype wire

//--- bench/rmc_i2c_host.sv
// Two-wire bus host model standing in for the baseband demodulator
`timescale 1ns/100ps
`default_nettype none
module rmc_i2c_host
(
	// Clock
	input  wire logic       core_clk,
	// Bus wires
	input  wire logic       sda_line,
	output logic            scl_drv,
	output logic            sda_drv,
	// Target address and pace
	input  wire logic [6:0] dev_addr,
	input  wire logic [3:0] phase_clks
);
	// --------
	// Bus phases
	// --------
	initial
	begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic tick();
		repeat (phase_clks) @(posedge core_clk);
		#1;
	endtask

	// Data moves two clocks after SCL falls, so the slave never sees it change with SCL high
	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	task automatic put_bit(input logic b, output logic r);
		settle();
		sda_drv = b;
		tick();
		scl_drv = 1'b1;
		tick();
		r = sda_line;
		scl_drv = 1'b0;
	endtask

	task automatic start_cond();
		settle();
		sda_drv = 1'b1;
		tick();
		scl_drv = 1'b1;
		tick();
		sda_drv = 1'b0;
		tick();
		scl_drv = 1'b0;
	endtask

	task automatic stop_cond();
		settle();
		sda_drv = 1'b0;
		tick();
		scl_drv = 1'b1;
		tick();
		sda_drv = 1'b1;
		tick();
	endtask

	// Ninth bit is always released: ack on writes, not-ack ends a read
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			put_bit(tx[i], r);
			rx[i] = r;
		end
		put_bit(1'b1, r);
		ack = ~r;
	endtask

	// --------
	// Register transfers
	// --------
	task automatic reg_write(input logic [7:0] ptr, input logic [7:0] data, output logic ok);
		logic [7:0] rx;
		logic       a0, a1, a2;
		start_cond();
		xfer({dev_addr, 1'b0}, rx, a0);
		xfer(ptr, rx, a1);
		xfer(data, rx, a2);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask

	task automatic reg_read(input logic [7:0] ptr, output logic [7:0] data, output logic ok);
		logic [7:0] rx;
		logic       a0, a1, a2, n;
		start_cond();
		xfer({dev_addr, 1'b0}, rx, a0);
		xfer(ptr, rx, a1);
		start_cond();
		xfer({dev_addr, 1'b1}, rx, a2);
		xfer(8'hff, data, n);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask
endmodule
`default_nettype wire

//--- bench/rmc_ctrl_tb_top.sv
// Self-checking bench for the receiver control register slice
`timescale 1ns/100ps
`default_nettype none
module rmc_ctrl_tb_top;
	logic                     core_clk, arst_n, enable_pin, rst_pin_n;
	logic [1:0]               addr_sel, addr_host;
	logic                     scl_drv, sda_drv, sda_out, sda_oe, pad_out, pad_oe;
	logic [4:0]               gain_db;
	logic [3:0]               phase_clks;
	rmc_pkg::rmc_block_en_t   block_en;
	rmc_pkg::rmc_power_mode_t power_mode;
	wire                      sda_line;
	int                       fail_count, tests_run, seed;
	int                       mdl [16];
	int                       gain_tab [4] = '{13, 11, 15, 13};

	// Open-drain line with pull-up
	assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

	rmc_ctrl rmc_ctrl_inst (.core_clk(core_clk), .arst_n(arst_n), .enable_pin(enable_pin),
		.rst_pin_n(rst_pin_n), .addr_select_pin0(addr_sel[0]), .addr_select_pin1(addr_sel[1]),
		.scl_in(scl_drv), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.logic_output_pad_out(pad_out), .logic_output_pad_oe(pad_oe),
		.post_mixer_amp_gain_db(gain_db), .block_en(block_en), .power_mode(power_mode));

	rmc_i2c_host rmc_i2c_host_inst (.core_clk(core_clk), .sda_line(sda_line), .scl_drv(scl_drv),
		.sda_drv(sda_drv), .dev_addr({rmc_pkg::BUS_ADDR_BASE, addr_host}),
		.phase_clks(phase_clks));

	// --------
	// Checking helpers
	// --------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_clks(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
		logic ok;
		rmc_i2c_host_inst.reg_write(ptr, data, ok);
		check("write ack", {7'h0, ok}, 8'h01);
		if (ptr == rmc_pkg::MODE_OFFSET)
			mdl[0] = data & 8'h07;
		if (ptr == rmc_pkg::MISC_OFFSET)
			mdl[6] = data & 8'hbf;
		if (ptr >= rmc_pkg::TEST_BASE_OFFSET && ptr < 8'h10 && mdl[0][2])
			mdl[ptr[3:0]] = data;
		wait_clks(4);
	endtask

	task automatic rd(input logic [7:0] ptr);
		logic       ok;
		logic [7:0] v;
		logic [7:0] e;
		rmc_i2c_host_inst.reg_read(ptr, v, ok);
		check("read ack", {7'h0, ok}, 8'h01);
		e = (ptr < 8'h10) ? 8'(mdl[ptr[3:0]]) : 8'h00;
		if (ptr >= rmc_pkg::TEST_BASE_OFFSET && !mdl[0][2])
			e = 8'h00;
		check($sformatf("reg %h", ptr), v, e);
	endtask

	// Expected pins worked out from the model registers and the enable pin
	task automatic chk_outs();
		logic [7:0]               m, c;
		logic [6:0]               be;
		rmc_pkg::rmc_power_mode_t pm;
		m = 8'(mdl[0]);
		c = 8'(mdl[6]);
		pm = !enable_pin ? rmc_pkg::PM_DEEP_SLEEP : m[0] ? rmc_pkg::PM_POWER_DOWN :
			c[0] ? rmc_pkg::PM_LOW_POWER : rmc_pkg::PM_NORMAL;
		be = (pm == rmc_pkg::PM_DEEP_SLEEP) ? 7'h00 : (pm == rmc_pkg::PM_POWER_DOWN) ? 7'h70 :
			{5'h1f, ~c[0], ~c[1]};
		check("power mode", {6'h0, power_mode}, {6'h0, pm});
		check("block enables", {1'b0, block_en}, {1'b0, be});
		check("gain", {3'h0, gain_db}, 8'(gain_tab[c[3:2]]));
		if (pm != rmc_pkg::PM_DEEP_SLEEP)
		begin
			check("pad out", {7'h0, pad_out}, {7'h0, c[4] & ~c[5]});
			check("pad oe", {7'h0, pad_oe}, {7'h0, ~(c[4] & c[5])});
		end
	endtask

	task automatic give_verdict();
		$display("checks run %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// --------
	// Clock, watchdog, sequence
	// --------
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	initial
	begin
		repeat (95000) @(posedge core_clk);
		fail_count++;
		$display("watchdog expired");
		give_verdict();
	end

	initial
	begin
		logic ok;
		seed = 32'ha8f9bdc5;
		arst_n = 1'b0;
		enable_pin = 1'b1;
		rst_pin_n = 1'b1;
		addr_sel = 2'b00;
		addr_host = 2'b00;
		phase_clks = 4'h6;
		fail_count = 0;
		tests_run = 0;
		mdl = '{default: 0};
		wait_clks(16);
		arst_n = 1'b1;
		wait_clks(8);
		for (int i = 0; i < 16; i++)
			rd(8'(i));
		chk_outs();
		$display("test reset values done");

		// Every gain code twice; bit 6 set at random to show it is dropped; bit 7 kept low
		for (int i = 0; i < 8; i++)
		begin
			wr(rmc_pkg::MISC_OFFSET, (8'($random(seed)) & 8'h73) | {4'h0, 2'(i), 2'b00});
			rd(rmc_pkg::MISC_OFFSET);
			chk_outs();
		end
		wr(rmc_pkg::MISC_OFFSET, 8'hc0);
		rd(rmc_pkg::MISC_OFFSET);
		wr(rmc_pkg::MISC_OFFSET, 8'h03);
		chk_outs();
		$display("test misc control done");

		wr(rmc_pkg::MODE_OFFSET, 8'hf9);
		rd(rmc_pkg::MODE_OFFSET);
		chk_outs();
		wr(rmc_pkg::MODE_OFFSET, 8'h00);
		for (int i = 7; i < 16; i++)
		begin
			wr(8'(i), 8'ha5);
			rd(8'(i));
		end
		wr(8'h03, 8'h5a);
		rd(8'h03);
		rd(8'h10);
		wr(rmc_pkg::MODE_OFFSET, 8'h04);
		wr(8'h09, 8'h3c);
		rd(8'h09);
		rd(8'h0f);
		wr(rmc_pkg::MODE_OFFSET, 8'h00);
		rd(8'h09);
		$display("test mode and test registers done");

		addr_host = 2'b11;
		rmc_i2c_host_inst.reg_write(rmc_pkg::MISC_OFFSET, 8'h10, ok);
		check("wrong address ack", {7'h0, ok}, 8'h00);
		addr_sel = 2'b10;
		addr_host = 2'b10;
		wait_clks(8);
		rd(rmc_pkg::MISC_OFFSET);
		$display("test bus address done");

		phase_clks = 4'hc;
		wr(rmc_pkg::MISC_OFFSET, 8'h35);
		wr(rmc_pkg::MODE_OFFSET, 8'h07);
		chk_outs();
		enable_pin = 1'b0;
		mdl[0] = mdl[0] & 6;
		wait_clks(8);
		chk_outs();
		rst_pin_n = 1'b0;
		wait_clks(16);
		rst_pin_n = 1'b1;
		wait_clks(8);
		enable_pin = 1'b1;
		wait_clks(64);
		chk_outs();
		rd(rmc_pkg::MODE_OFFSET);
		rd(rmc_pkg::MISC_OFFSET);
		phase_clks = 4'h6;
		$display("test deep sleep done");

		rst_pin_n = 1'b0;
		wait_clks(8);
		rst_pin_n = 1'b1;
		mdl = '{default: 0};
		wait_clks(8);
		rd(rmc_pkg::MODE_OFFSET);
		rd(rmc_pkg::MISC_OFFSET);
		wr(rmc_pkg::MISC_OFFSET, 8'h2a);
		arst_n = 1'b0;
		wait_clks(4);
		arst_n = 1'b1;
		mdl = '{default: 0};
		wait_clks(8);
		rd(rmc_pkg::MISC_OFFSET);
		chk_outs();
		$display("test resets done");
		give_verdict();
	end
endmodule
`default_nettype wire
